// ---- operating_mode_sequencer.sv ----
// Purpose: operating mode state machine of the modem core
// Assumes: host commands and rf start, pending and end events are one-cycle pulses on core_clk_i; data_busy is a level
// Notes: power-on input is a pin, active low, synchronised here
`timescale 1ns/1ps

// How it works
// - power saving starts off; only the config command enables it.
// - off goes to active only after a clean power-on press.
// - sleep wakes to active on update timer expiry or power-on press.
// - active goes to off after a clean switch-off procedure.
// - active drops to sleep when allowed and power saving is on.
// - active goes connected on connection start or pending rf activity.
// - connected returns to active when the connection ends or suspends.
// - idle connected falls to active, then sleeps if power saving on.
// - rf need in sleep wakes to active first, then to connected.
// - active keeps application interfaces on whatever the power saving setting.
// - connected mode is ready for host data.
// - sleep keeps only slow reference; rf and interfaces off.
// - switch-off via off command or power-on press from active.
module operating_mode_sequencer
  import opmode_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // host side
  input wire logic power_on_input_b_i,
  input wire host_cmd_t host_cmd_i,
  // rf and protocol side
  input wire rf_evt_t rf_evt_i,
  input wire logic update_timer_exp_i,
  input wire logic sleep_allowed_i,
  // status
  output op_mode_t mode_o,
  output mode_out_t mode_en_o,
  output logic power_saving_o
);

  // ==========================================================
  // reset release
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ==========================================================
  // power-on input
  logic pwr_pressed_s;
  logic press_done;

  // pin is active low; invert before sync so the sync is plain
  sync2 u_pwr_sync (
    .clk_i(core_clk_i),
    .rst_b_i(rst_sync_r),
    .d_i(~power_on_input_b_i),
    .q_o(pwr_pressed_s)
  );

  press_detect u_press (
    .clk_i(core_clk_i),
    .rst_b_i(rst_sync_r),
    .pressed_i(pwr_pressed_s),
    .done_o(press_done)
  );

  // ==========================================================
  // power saving setting
  logic ps_en_r;

  always_ff @(posedge core_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ps_en_r <= 1'b0;
    end else if (host_cmd_i.power_saving_config_command) begin
      ps_en_r <= host_cmd_i.power_saving_value;
    end
  end

  // ==========================================================
  // pending rf need, latched while asleep or waking
  logic rf_want_r;
  logic rf_want_nxt;
  op_mode_t mode_r;
  op_mode_t mode_nxt;

  always_comb begin
    rf_want_nxt = rf_want_r;
    // a new rf need beats an end seen in the same cycle
    if (rf_evt_i.conn_end) begin
      rf_want_nxt = 1'b0;
    end
    if (mode_r == MODE_CONNECTED || mode_r == MODE_OFF) begin
      rf_want_nxt = 1'b0;
    end else if (rf_evt_i.conn_start || rf_evt_i.conn_pending) begin
      rf_want_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rf_want_r <= 1'b0;
    end else begin
      rf_want_r <= rf_want_nxt;
    end
  end

  // ==========================================================
  // settle counter: active must be seen for a while before sleep,
  // so a just-woken device has a chance to serve the host
  logic [3:0] hold_r;

  always_ff @(posedge core_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      hold_r <= 4'h0;
    end else if (mode_r != MODE_ACTIVE) begin
      hold_r <= 4'h0;
    end else if (hold_r != SLEEP_HOLD_CYC) begin
      hold_r <= hold_r + 4'h1;
    end
  end

  logic can_sleep;
  assign can_sleep = ps_en_r && sleep_allowed_i && !rf_want_r &&
                     (hold_r == SLEEP_HOLD_CYC);

  // ==========================================================
  // mode state machine
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      MODE_OFF: begin
        if (press_done) begin
          mode_nxt = MODE_ACTIVE;
        end
      end
      MODE_SLEEP: begin
        // rf need only wakes; connected comes from active next
        if (update_timer_exp_i || press_done || rf_want_r) begin
          mode_nxt = MODE_ACTIVE;
        end
      end
      MODE_ACTIVE: begin
        // switch-off has priority over any rf or sleep trigger
        if (host_cmd_i.switch_off_command || press_done) begin
          mode_nxt = MODE_OFF;
        end else if (rf_evt_i.conn_start || rf_evt_i.conn_pending ||
                     rf_want_r) begin
          mode_nxt = MODE_CONNECTED;
        end else if (can_sleep) begin
          mode_nxt = MODE_SLEEP;
        end
      end
      MODE_CONNECTED: begin
        if (rf_evt_i.conn_end || !rf_evt_i.data_busy) begin
          mode_nxt = MODE_ACTIVE;
        end
      end
      default: begin
        mode_nxt = MODE_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      mode_r <= MODE_OFF;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ==========================================================
  // mode outputs, registered from the next mode so they track mode_r
  mode_out_t en_r;
  mode_out_t en_nxt;

  always_comb begin
    en_nxt = '0;
    unique case (mode_nxt)
      MODE_ACTIVE: begin
        en_nxt.core_ref_en = 1'b1;
        en_nxt.slow_ref_en = 1'b1;
        en_nxt.app_if_en = 1'b1;
      end
      MODE_CONNECTED: begin
        en_nxt.core_ref_en = 1'b1;
        en_nxt.slow_ref_en = 1'b1;
        en_nxt.rf_en = 1'b1;
        en_nxt.app_if_en = 1'b1;
        en_nxt.host_data_rdy = 1'b1;
      end
      MODE_SLEEP: begin
        en_nxt.slow_ref_en = 1'b1;
      end
      default: begin
        en_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      en_r <= '0;
    end else begin
      en_r <= en_nxt;
    end
  end

  assign mode_o = mode_r;
  assign mode_en_o = en_r;
  assign power_saving_o = ps_en_r;

endmodule

// ---- opmode_pkg.sv ----
// Purpose: shared types and constants for the operating mode sequencer
// Assumes: single 20 MHz core clock
// Notes: procedure detection widths are kept small and fixed
package opmode_pkg;

  // ==========================================================
  // operating modes
  typedef enum logic [3:0] {
    MODE_OFF       = 4'h1,
    MODE_ACTIVE    = 4'h2,
    MODE_CONNECTED = 4'h4,
    MODE_SLEEP     = 4'h8
  } op_mode_t;

  // ==========================================================
  // timing
  localparam int CLK_HZ = 20000000;
  // press on the power-on input that counts as a clean procedure, in us
  localparam int PRESS_US = 100;
  localparam int PRESS_CYC = (CLK_HZ / 1000000) * PRESS_US;
  localparam int PRESS_W = 12;
  // settle time spent in active before sleep is taken, in cycles
  localparam logic [3:0] SLEEP_HOLD_CYC = 4'h8;

  // ==========================================================
  // host events gathered together
  typedef struct packed {
    logic switch_off_command;
    logic power_saving_config_command;
    logic power_saving_value;
  } host_cmd_t;

  // rf side status gathered together
  typedef struct packed {
    logic conn_start;
    logic conn_pending;
    logic data_busy;
    logic conn_end;
  } rf_evt_t;

  // enables shown to the rest of the module
  typedef struct packed {
    logic core_ref_en;
    logic slow_ref_en;
    logic rf_en;
    logic app_if_en;
    logic host_data_rdy;
  } mode_out_t;

endpackage

// ---- sync2.sv ----
// Purpose: two flop synchroniser for a level
// Assumes: input is asynchronous to clk_i
// Notes: first flop feeds only the second
`timescale 1ns/1ps
module sync2
  import opmode_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // data
  input wire logic d_i,
  output logic q_o
);
  logic meta_r;
  logic q_r;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= 1'b0;
      q_r <= 1'b0;
    end else begin
      meta_r <= d_i;
      q_r <= meta_r;
    end
  end

  assign q_o = q_r;
endmodule

// ---- press_detect.sv ----
// Purpose: recognises a clean press on the power-on input
// Assumes: input already synchronised, active high when pressed
// Notes: a press shorter than PRESS_CYC is ignored as a glitch
`timescale 1ns/1ps
module press_detect
  import opmode_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // pin level and result
  input wire logic pressed_i,
  output logic done_o
);
  logic [PRESS_W-1:0] cnt_r;
  logic long_r;
  logic done_r;

  // ==========================================================
  // count held level, report on release so one press gives one pulse
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= '0;
      long_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (pressed_i) begin
        if (cnt_r == PRESS_W'(PRESS_CYC - 1)) begin
          long_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end else begin
        done_r <= long_r;
        long_r <= 1'b0;
        cnt_r <= '0;
      end
    end
  end

  assign done_o = done_r;
endmodule

// ---- opmode_properties.sv ----
// Purpose: port checks for the operating mode sequencer
// Assumes: single core clock, async active low reset
// Notes: bound from the bench top file
`timescale 1ns/1ps
module opmode_properties
  import opmode_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // inputs
  input wire logic power_on_input_b_i,
  input wire host_cmd_t host_cmd_i,
  input wire rf_evt_t rf_evt_i,
  input wire logic update_timer_exp_i,
  input wire logic sleep_allowed_i,
  // outputs
  input wire op_mode_t mode_o,
  input wire mode_out_t mode_en_o,
  input wire logic power_saving_o
);
  // ==========================================================
  // mode checks
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence in_sleep;
    mode_o == MODE_SLEEP;
  endsequence
  sequence rf_need;
    rf_evt_i.conn_start || rf_evt_i.conn_pending;
  endsequence
  chk_ps_hold: assert property (
    !power_saving_o && !host_cmd_i.power_saving_config_command
    |=> !power_saving_o) else $error("power saving set unasked");
  chk_timer_wake: assert property (
    in_sleep ##0 update_timer_exp_i |=> mode_o == MODE_ACTIVE)
    else $error("timer did not wake");
  chk_wake_step: assert property (
    in_sleep ##0 rf_need |=> ##[0:1] mode_o == MODE_ACTIVE)
    else $error("rf wake skipped active");
  chk_no_skip: assert property (
    in_sleep |=> mode_o != MODE_CONNECTED)
    else $error("sleep went straight to connected");
  chk_off_cmd: assert property (
    mode_o == MODE_ACTIVE && host_cmd_i.switch_off_command
    |=> mode_o == MODE_OFF) else $error("switch off ignored");
  chk_no_sleep: assert property (
    mode_o != MODE_SLEEP && !power_saving_o |=> mode_o != MODE_SLEEP)
    else $error("slept with saving off");
  chk_sleep_refs: assert property (
    in_sleep |-> mode_en_o == 5'h08) else $error("sleep enables wrong");
  chk_conn_ready: assert property (
    mode_o == MODE_CONNECTED |-> mode_en_o.rf_en && mode_en_o.host_data_rdy)
    else $error("connected not ready");
  chk_conn_go: assert property (
    mode_o == MODE_ACTIVE && rf_evt_i.conn_start
    && !host_cmd_i.switch_off_command |=> mode_o == MODE_CONNECTED)
    else $error("no connect");
  chk_conn_end: assert property (
    mode_o == MODE_CONNECTED && rf_evt_i.conn_end |=> mode_o == MODE_ACTIVE)
    else $error("connection end ignored");
endmodule

// ---- opmode_host_model.sv ----
// Purpose: host processor driving power-on pin and commands
// Assumes: pin idles high through a pull-up
// Notes: press length is chosen by the caller
`timescale 1ns/1ps
module opmode_host_model
  import opmode_pkg::*;
(
  // clock
  input wire logic core_clk_i,
  // host outputs
  output logic power_on_input_b_o,
  output host_cmd_t host_cmd_o
);
  initial begin
    power_on_input_b_o = 1'b1;
    host_cmd_o = '0;
  end
  // ==========================================================
  // procedures
  task automatic press(input int cyc);
    @(posedge core_clk_i);
    power_on_input_b_o <= 1'b0;
    repeat (cyc) @(posedge core_clk_i);
    power_on_input_b_o <= 1'b1;
  endtask
  // commands are one-cycle pulses
  task automatic send(input host_cmd_t c);
    @(posedge core_clk_i);
    host_cmd_o <= c;
    @(posedge core_clk_i);
    host_cmd_o <= '0;
  endtask
endmodule

// ---- operating_mode_sequencer_tb_top.sv ----
// Purpose: self-checking bench for the operating mode sequencer
// Assumes: 20 MHz clock, 12 cycle reset
// Notes: clean presses run 2010 cycles, past the 2000 minimum
`timescale 1ns/1ps
module operating_mode_sequencer_tb_top;
  import opmode_pkg::*;
  logic core_clk_i;
  logic rst_b_i;
  logic pin_b;
  host_cmd_t cmd;
  logic [4:0] pls;
  logic busy;
  logic slp_ok;
  rf_evt_t rf;
  op_mode_t mode;
  mode_out_t en;
  logic ps;
  int failures = 0;
  int check_count = 0;
  assign rf = {pls[3:2], busy, pls[0]};
  always #25 core_clk_i = ~core_clk_i;
  opmode_host_model host (.core_clk_i(core_clk_i),
    .power_on_input_b_o(pin_b), .host_cmd_o(cmd));
  operating_mode_sequencer dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .power_on_input_b_i(pin_b), .host_cmd_i(cmd), .rf_evt_i(rf),
    .update_timer_exp_i(pls[4]), .sleep_allowed_i(slp_ok),
    .mode_o(mode), .mode_en_o(en), .power_saving_o(ps));
  // ==========================================================
  // helpers
  task automatic chk(input string n, input logic [4:0] e, logic [4:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // bounded wait, so a stuck mode is reported not hung
  task automatic wait_mode(input op_mode_t m, input int lim);
    for (int i = 0; i < lim && mode !== m; i++) tick(1);
    chk("mode", 5'(m), 5'(mode));
  endtask
  task automatic pulse(input logic [4:0] p);
    @(posedge core_clk_i);
    pls <= p;
    @(posedge core_clk_i);
    pls <= '0;
    #1;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_boot;
    chk("ps", 5'h00, 5'(ps));
    pulse(5'h08);
    chk("mode", 5'(MODE_OFF), 5'(mode));
    host.press(100);
    tick(10);
    chk("mode", 5'(MODE_OFF), 5'(mode));
    host.press(2010);
    wait_mode(MODE_ACTIVE, 8);
    chk("app", 5'h01, 5'(en.app_if_en));
    $display("test boot done");
  endtask
  task automatic t_conn;
    @(posedge core_clk_i) busy <= 1'b1;
    pulse(5'h08);
    chk("mode", 5'(MODE_CONNECTED), 5'(mode));
    chk("rdy", 5'h01, 5'(en.host_data_rdy));
    pulse(5'h01);
    chk("mode", 5'(MODE_ACTIVE), 5'(mode));
    $display("test conn done");
  endtask
  task automatic t_sleep;
    host.send(3'b011);
    tick(1);
    chk("ps", 5'h01, 5'(ps));
    @(posedge core_clk_i) slp_ok <= 1'b1;
    @(posedge core_clk_i) busy <= 1'b0;
    wait_mode(MODE_SLEEP, 20);
    chk("en", 5'h08, en);
    pulse(5'h10);
    chk("mode", 5'(MODE_ACTIVE), 5'(mode));
    wait_mode(MODE_SLEEP, 20);
    @(posedge core_clk_i) busy <= 1'b1;
    pulse(5'h04);
    tick(1);
    chk("mode", 5'(MODE_ACTIVE), 5'(mode));
    tick(1);
    chk("mode", 5'(MODE_CONNECTED), 5'(mode));
    @(posedge core_clk_i) busy <= 1'b0;
    wait_mode(MODE_ACTIVE, 3);
    wait_mode(MODE_SLEEP, 20);
    @(posedge core_clk_i) slp_ok <= 1'b0;
    host.press(2010);
    wait_mode(MODE_ACTIVE, 8);
    host.send(3'b010);
    slp_ok <= 1'b1;
    tick(20);
    chk("mode", 5'(MODE_ACTIVE), 5'(mode));
    $display("test sleep done");
  endtask
  task automatic t_off;
    host.send(3'b100);
    tick(0);
    chk("mode", 5'(MODE_OFF), 5'(mode));
    host.press(2010);
    wait_mode(MODE_ACTIVE, 8);
    host.press(2010);
    wait_mode(MODE_OFF, 8);
    $display("test off done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    core_clk_i = 1'b0;
    rst_b_i = 1'b0;
    pls = '0;
    busy = 1'b0;
    slp_ok = 1'b0;
    repeat (12) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    tick(4);
    t_boot();
    t_conn();
    t_sleep();
    t_off();
    test_done();
  end
  // about 8k cycles expected; cut off well beyond
  initial begin
    repeat (40000) @(posedge core_clk_i);
    failures++;
    test_done();
  end
endmodule
bind operating_mode_sequencer opmode_properties chk_i (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
  .power_on_input_b_i(power_on_input_b_i), .host_cmd_i(host_cmd_i),
  .rf_evt_i(rf_evt_i), .update_timer_exp_i(update_timer_exp_i),
  .sleep_allowed_i(sleep_allowed_i), .mode_o(mode_o),
  .mode_en_o(mode_en_o), .power_saving_o(power_saving_o));
